/* design/rx_sequencer_exit_routing.sv */
// Sequencer exit routing from Receive and packet-done, with AXI4-Lite registers
// Functional notes
// - Bits 7-5 choose the Receive exit.
// - Code 001: payload complete goes to packet-done.
// - Code 010: payload complete goes to low power.
// - Code 011: CRC pass goes to packet-done.
// - Code 100: signal level halts the sequencer.
// - Code 101: sync match halts the sequencer.
// - Code 110: preamble found halts the sequencer.
// - Bits 4-3 route timeouts, and payload under 011.
// - Timeout code 00 relaunches the receiver.
// - Timeout 01 transmit, 10 low power, 11 halt.
// - Any of three wait timeouts is a timeout.
// - Bits 2-0, reset zero, choose packet-done exit.
// - Code 000 halts straight from packet-done.
// - Code 001 transmits once the FIFO empties.
// - Code 010 goes to the low-power target.
// - Code 011 reenters Receive, via frequency synthesis if the frequency changed.
// - Code 100 reenters Receive with no change.
// - Low-power target: halted if 0, idle if 1.
//
// Decided for this implementation: the AXI4-Lite slave port.
`timescale 1ns/1ps
`default_nettype none
`include "seq_exit_consts.svh"

module rx_sequencer_exit_routing (
  // Clock and reset
  input  wire logic                   CLK_IN,
  input  wire logic                   NRST_IN,
  // AXI4-Lite write address
  input  wire logic [`ADDR_W-1:0]     AWADDR_IN,
  input  wire logic                   AWVALID_IN,
  output logic                        AWREADY_OUT,
  // AXI4-Lite write data
  input  wire logic [`DATA_W-1:0]     WDATA_IN,
  input  wire logic [3:0]             WSTRB_IN,
  input  wire logic                   WVALID_IN,
  output logic                        WREADY_OUT,
  // AXI4-Lite write response
  output logic [1:0]                  BRESP_OUT,
  output logic                        BVALID_OUT,
  input  wire logic                   BREADY_IN,
  // AXI4-Lite read address
  input  wire logic [`ADDR_W-1:0]     ARADDR_IN,
  input  wire logic                   ARVALID_IN,
  output logic                        ARREADY_OUT,
  // AXI4-Lite read data
  output logic [`DATA_W-1:0]          RDATA_OUT,
  output logic [1:0]                  RRESP_OUT,
  output logic                        RVALID_OUT,
  input  wire logic                   RREADY_IN,
  // Packet engine events
  input  wire logic                   PAYLOAD_COMPLETE_FLAG_IN,
  input  wire logic                   CRC_PASS_FLAG_IN,
  input  wire logic                   SIGNAL_LEVEL_FLAG_IN,
  input  wire logic                   SYNC_MATCH_FLAG_IN,
  input  wire logic                   PREAMBLE_FOUND_FLAG_IN,
  input  wire logic                   SIGNAL_WAIT_TIMEOUT_IN,
  input  wire logic                   PREAMBLE_WAIT_TIMEOUT_IN,
  input  wire logic                   SYNC_WAIT_TIMEOUT_IN,
  input  wire logic                   FIFO_EMPTY_FLAG_IN,
  input  wire logic                   FREQ_CHANGED_IN,
  // Sequencer state
  output logic [2:0]                  STATE_OUT,
  output logic                        IDLE_SLEEP_OUT
);

  // Register bits
  logic [7:0]                 rx_cfg;
  logic [1:0]                 lp_cfg;
  logic                       timeout_seen;
  seq_exit_pkg::seq_state_t   state;
  seq_exit_pkg::seq_state_t   next_state;

  // Bus holding state
  logic [`ADDR_W-1:0]         aw_addr;
  logic                       aw_held;
  logic [`DATA_W-1:0]         w_data;
  logic [3:0]                 w_strb;
  logic                       w_held;
  logic                       bvalid;
  logic [1:0]                 bresp;
  logic                       rvalid;
  logic [1:0]                 rresp;
  logic [`DATA_W-1:0]         rdata;

  // Configuration fields as types
  seq_exit_pkg::rx_exit_t      rx_sel;
  seq_exit_pkg::timeout_exit_t to_sel;
  seq_exit_pkg::pkt_exit_t     pkt_sel;
  logic                        lp_sel;
  logic                        idle_chip_select;

  assign rx_sel  = seq_exit_pkg::rx_exit_t'(rx_cfg[`RX_SEL_HI:`RX_SEL_LO]);
  assign to_sel  = seq_exit_pkg::timeout_exit_t'(rx_cfg[`TO_SEL_HI:`TO_SEL_LO]);
  assign pkt_sel = seq_exit_pkg::pkt_exit_t'(rx_cfg[`PKT_SEL_HI:`PKT_SEL_LO]);
  assign lp_sel           = lp_cfg[0];
  assign idle_chip_select = lp_cfg[1];

  // Receive timeout is any one of the wait timeouts
  logic receive_timeout_event;
  assign receive_timeout_event = SIGNAL_WAIT_TIMEOUT_IN | PREAMBLE_WAIT_TIMEOUT_IN |
                                 SYNC_WAIT_TIMEOUT_IN;

  // Handshake readiness
  assign AWREADY_OUT = !aw_held && !bvalid;
  assign WREADY_OUT  = !w_held && !bvalid;
  assign ARREADY_OUT = !rvalid;

  // Write decode, performed once both halves are held
  logic wr_do;
  logic wr_lane0;
  logic sel_w_cfg;
  logic sel_w_ctrl;
  logic sel_w_stat;
  logic wr_mapped;
  assign wr_do      = aw_held && w_held && !bvalid;
  assign wr_lane0   = w_strb[0];
  assign sel_w_cfg  = (aw_addr == `RX_CFG_ADDR);
  assign sel_w_ctrl = (aw_addr == `CTRL_ADDR);
  assign sel_w_stat = (aw_addr == `STATUS_ADDR);
  assign wr_mapped  = sel_w_cfg || sel_w_ctrl || sel_w_stat;

  // Write and command strobes from configuration, control and status writes
  logic launch_cmd;
  logic stop_cmd;
  logic cfg_we;
  logic ctrl_we;
  logic seen_clr;
  assign ctrl_we    = wr_do && sel_w_ctrl && wr_lane0;
  assign cfg_we     = wr_do && sel_w_cfg && wr_lane0;
  assign launch_cmd = ctrl_we && w_data[`LAUNCH_BIT];
  assign stop_cmd   = ctrl_we && w_data[`STOP_BIT];
  assign seen_clr   = wr_do && sel_w_stat && wr_lane0 && w_data[`TIMEOUT_BIT];

  // Read decode
  logic ar_take;
  logic sel_r_cfg;
  logic sel_r_ctrl;
  logic sel_r_stat;
  logic [`DATA_W-1:0] rd_word;
  assign ar_take    = ARVALID_IN && !rvalid;
  assign sel_r_cfg  = (ARADDR_IN == `RX_CFG_ADDR);
  assign sel_r_ctrl = (ARADDR_IN == `CTRL_ADDR);
  assign sel_r_stat = (ARADDR_IN == `STATUS_ADDR);
  assign rd_word = sel_r_cfg  ? {24'h0000_00, rx_cfg} :
                   sel_r_ctrl ? {28'h000_0000, idle_chip_select, lp_sel, 2'h0} :
                   sel_r_stat ? {28'h000_0000, timeout_seen, state} :
                                32'h0000_0000;

  // Write address capture
  always_ff @(posedge CLK_IN or negedge NRST_IN) begin
    if (!NRST_IN) begin
      aw_held <= 1'b0;
      aw_addr <= '0;
    end else if (AWVALID_IN && AWREADY_OUT) begin
      aw_held <= 1'b1;
      aw_addr <= AWADDR_IN;
    end else if (wr_do) begin
      aw_held <= 1'b0;
    end
  end

  // Write data capture
  always_ff @(posedge CLK_IN or negedge NRST_IN) begin
    if (!NRST_IN) begin
      w_held <= 1'b0;
      w_data <= '0;
      w_strb <= '0;
    end else if (WVALID_IN && WREADY_OUT) begin
      w_held <= 1'b1;
      w_data <= WDATA_IN;
      w_strb <= WSTRB_IN;
    end else if (wr_do) begin
      w_held <= 1'b0;
    end
  end

  // Write response
  always_ff @(posedge CLK_IN or negedge NRST_IN) begin
    if (!NRST_IN) begin
      bvalid <= 1'b0;
      bresp  <= `RESP_OKAY;
    end else if (wr_do) begin
      bvalid <= 1'b1;
      bresp  <= wr_mapped ? `RESP_OKAY : `RESP_SLVERR;
    end else if (BREADY_IN) begin
      bvalid <= 1'b0;
    end
  end

  // Read response
  always_ff @(posedge CLK_IN or negedge NRST_IN) begin
    if (!NRST_IN) begin
      rvalid <= 1'b0;
      rresp  <= `RESP_OKAY;
      rdata  <= '0;
    end else if (ar_take) begin
      rvalid <= 1'b1;
      rresp  <= (sel_r_cfg || sel_r_ctrl || sel_r_stat) ? `RESP_OKAY : `RESP_SLVERR;
      rdata  <= rd_word;
    end else if (RREADY_IN) begin
      rvalid <= 1'b0;
    end
  end

  // Exit configuration register
  always_ff @(posedge CLK_IN or negedge NRST_IN) begin
    if (!NRST_IN) begin
      rx_cfg <= `RX_CFG_RESET;
    end else if (cfg_we) begin
      rx_cfg <= w_data[`RX_SEL_HI:`PKT_SEL_LO];
    end
  end

  // Low-power selection bits of the control register
  always_ff @(posedge CLK_IN or negedge NRST_IN) begin
    if (!NRST_IN) begin
      lp_cfg <= `CTRL_RESET;
    end else if (ctrl_we) begin
      lp_cfg <= {w_data[`IDLE_SLEEP_BIT], w_data[`LP_SEL_BIT]};
    end
  end

  // Sticky timeout flag, a new timeout beats the clear
  always_ff @(posedge CLK_IN or negedge NRST_IN) begin
    if (!NRST_IN) begin
      timeout_seen <= 1'b0;
    end else if (receive_timeout_event) begin
      timeout_seen <= 1'b1;
    end else if (seen_clr) begin
      timeout_seen <= 1'b0;
    end
  end

  // Next-state selection
  seq_next_state u_next (
    .state_in        (state),
    .rx_sel_in       (rx_sel),
    .to_sel_in       (to_sel),
    .pkt_sel_in      (pkt_sel),
    .lp_sel_in       (lp_sel),
    .launch_in       (launch_cmd),
    .stop_in         (stop_cmd),
    .payload_in      (PAYLOAD_COMPLETE_FLAG_IN),
    .crc_in          (CRC_PASS_FLAG_IN),
    .level_in        (SIGNAL_LEVEL_FLAG_IN),
    .sync_in         (SYNC_MATCH_FLAG_IN),
    .preamble_in     (PREAMBLE_FOUND_FLAG_IN),
    .timeout_in      (receive_timeout_event),
    .fifo_empty_in   (FIFO_EMPTY_FLAG_IN),
    .freq_changed_in (FREQ_CHANGED_IN),
    .next_state_out  (next_state)
  );

  // Sequencer state register, sleep indication registered beside it
  logic idle_sleep;
  logic next_idle_sleep;
  assign next_idle_sleep = (next_state == seq_exit_pkg::IDLE) &&
                           (ctrl_we ? w_data[`IDLE_SLEEP_BIT] : idle_chip_select);
  always_ff @(posedge CLK_IN or negedge NRST_IN) begin
    if (!NRST_IN) begin
      state      <= seq_exit_pkg::HALTED;
      idle_sleep <= 1'b0;
    end else begin
      state      <= next_state;
      idle_sleep <= next_idle_sleep;
    end
  end

  // Outputs
  assign BVALID_OUT     = bvalid;
  assign BRESP_OUT      = bresp;
  assign RVALID_OUT     = rvalid;
  assign RRESP_OUT      = rresp;
  assign RDATA_OUT      = rdata;
  assign STATE_OUT      = state;
  assign IDLE_SLEEP_OUT = idle_sleep;

  // Checks
  default clocking cb @(posedge CLK_IN);
  endclocking
  default disable iff (!NRST_IN);

  logic in_rx;
  logic in_pkt;
  logic rx_unused;
  assign in_rx     = (state == seq_exit_pkg::RECEIVE) && !stop_cmd;
  assign in_pkt    = (state == seq_exit_pkg::PACKET_DONE) && !stop_cmd;
  assign rx_unused = (rx_sel == seq_exit_pkg::RX_UNUSED_LO) ||
                     (rx_sel == seq_exit_pkg::RX_UNUSED_HI);

  sequence s_timeout_relaunch;
    in_rx && rx_unused && receive_timeout_event && (to_sel == seq_exit_pkg::TO_RELAUNCH)
      ##1 !stop_cmd;
  endsequence

  sequence s_fs_start;
    in_pkt && (pkt_sel == seq_exit_pkg::PKT_RX_VIA_FS) && FREQ_CHANGED_IN ##1 !stop_cmd;
  endsequence

  a_rx_payload_pkt: assert property (in_rx && (rx_sel == seq_exit_pkg::RX_PKT_ON_PAYLOAD) &&
      PAYLOAD_COMPLETE_FLAG_IN |=> state == seq_exit_pkg::PACKET_DONE)
    else $error("payload exit to packet-done missed");

  a_rx_payload_lp: assert property (in_rx && (rx_sel == seq_exit_pkg::RX_LP_ON_PAYLOAD) &&
      PAYLOAD_COMPLETE_FLAG_IN |=> state == ($past(lp_sel) ? seq_exit_pkg::IDLE :
      seq_exit_pkg::HALTED))
    else $error("payload exit to low power wrong");

  a_rx_crc_exit: assert property (in_rx && (rx_sel == seq_exit_pkg::RX_PKT_ON_CRC) &&
      CRC_PASS_FLAG_IN |=> state == seq_exit_pkg::PACKET_DONE)
    else $error("crc exit to packet-done missed");

  a_rx_halt_events: assert property (in_rx && (
      ((rx_sel == seq_exit_pkg::RX_HALT_ON_LEVEL) && SIGNAL_LEVEL_FLAG_IN) ||
      ((rx_sel == seq_exit_pkg::RX_HALT_ON_SYNC) && SYNC_MATCH_FLAG_IN) ||
      ((rx_sel == seq_exit_pkg::RX_HALT_ON_PREAMB) && PREAMBLE_FOUND_FLAG_IN))
      |=> state == seq_exit_pkg::HALTED)
    else $error("event halt exit missed");

  a_timeout_relaunch: assert property (s_timeout_relaunch |->
      (state == seq_exit_pkg::RELAUNCH) ##1 (state == seq_exit_pkg::RECEIVE))
    else $error("timeout relaunch path wrong");

  a_timeout_route: assert property (in_rx && rx_unused && receive_timeout_event &&
      (to_sel != seq_exit_pkg::TO_RELAUNCH) |=> state ==
      (($past(to_sel) == seq_exit_pkg::TO_TRANSMIT) ? seq_exit_pkg::TRANSMIT :
       ($past(to_sel) == seq_exit_pkg::TO_HALT) ? seq_exit_pkg::HALTED :
       $past(lp_sel) ? seq_exit_pkg::IDLE : seq_exit_pkg::HALTED))
    else $error("timeout route wrong");

  a_crc_payload_to: assert property (in_rx && (rx_sel == seq_exit_pkg::RX_PKT_ON_CRC) &&
      !CRC_PASS_FLAG_IN && PAYLOAD_COMPLETE_FLAG_IN && (to_sel == seq_exit_pkg::TO_TRANSMIT)
      |=> state == seq_exit_pkg::TRANSMIT)
    else $error("payload under crc mode ignored timeout route");

  a_rx_unused_stay: assert property (in_rx && rx_unused && !receive_timeout_event
      |=> state == seq_exit_pkg::RECEIVE)
    else $error("unused receive code left receive");

  a_pkt_halt: assert property (in_pkt && (pkt_sel == seq_exit_pkg::PKT_HALT)
      |=> state == seq_exit_pkg::HALTED)
    else $error("packet-done halt missed");

  a_pkt_fifo_wait: assert property (in_pkt && (pkt_sel == seq_exit_pkg::PKT_TX_ON_FE)
      |=> state == ($past(FIFO_EMPTY_FLAG_IN) ? seq_exit_pkg::TRANSMIT :
      seq_exit_pkg::PACKET_DONE))
    else $error("fifo-empty transmit exit wrong");

  a_pkt_low_power: assert property (in_pkt && (pkt_sel == seq_exit_pkg::PKT_LOW_PWR)
      |=> state == ($past(lp_sel) ? seq_exit_pkg::IDLE : seq_exit_pkg::HALTED))
    else $error("packet-done low power exit wrong");

  a_pkt_fs_path: assert property (s_fs_start |->
      (state == seq_exit_pkg::FREQ_SYNTH) ##1 (state == seq_exit_pkg::RECEIVE))
    else $error("frequency synthesis path wrong");

  a_pkt_rx_direct: assert property (in_pkt && (pkt_sel == seq_exit_pkg::PKT_RX_DIRECT)
      |=> state == seq_exit_pkg::RECEIVE)
    else $error("direct receive reentry missed");

  a_launch_gate: assert property (launch_cmd && !stop_cmd &&
      (state == seq_exit_pkg::TRANSMIT) |=> state == seq_exit_pkg::TRANSMIT)
    else $error("launch honoured outside low power");

endmodule : rx_sequencer_exit_routing

`default_nettype wire

/* design/seq_exit_consts.svh */
// Register map, field positions and reset values of the sequencer exit block
`ifndef SEQ_EXIT_CONSTS_SVH
`define SEQ_EXIT_CONSTS_SVH

// Bus geometry
`define ADDR_W          12
`define DATA_W          32
`define RESP_OKAY       2'h0
`define RESP_SLVERR     2'h2

// Register indices; byte address is four times the index
`define RX_CFG_INDEX    10'h037
`define CTRL_INDEX      10'h040
`define STATUS_INDEX    10'h041
`define RX_CFG_ADDR     ({`RX_CFG_INDEX, 2'h0})
`define CTRL_ADDR       ({`CTRL_INDEX, 2'h0})
`define STATUS_ADDR     ({`STATUS_INDEX, 2'h0})

// Exit configuration fields
`define RX_SEL_HI       7
`define RX_SEL_LO       5
`define TO_SEL_HI       4
`define TO_SEL_LO       3
`define PKT_SEL_HI      2
`define PKT_SEL_LO      0
`define RX_CFG_RESET    8'h00

// Control register bits
`define LAUNCH_BIT      0
`define STOP_BIT        1
`define LP_SEL_BIT      2
`define IDLE_SLEEP_BIT  3
`define CTRL_RESET      2'h0

// Status register bits
`define STATE_HI        2
`define STATE_LO        0
`define TIMEOUT_BIT     3

`endif

/* design/seq_exit_pkg.sv */
// Types shared by the sequencer exit block
package seq_exit_pkg;

  // Sequencer states, Gray along halted-idle-receive-packet path
  typedef enum logic [2:0] {
    HALTED      = 3'h0,
    IDLE        = 3'h1,
    RECEIVE     = 3'h3,
    PACKET_DONE = 3'h2,
    FREQ_SYNTH  = 3'h6,
    TRANSMIT    = 3'h7,
    RELAUNCH    = 3'h5
  } seq_state_t;

  // Exit choices out of Receive
  typedef enum logic [2:0] {
    RX_UNUSED_LO      = 3'h0,
    RX_PKT_ON_PAYLOAD = 3'h1,
    RX_LP_ON_PAYLOAD  = 3'h2,
    RX_PKT_ON_CRC     = 3'h3,
    RX_HALT_ON_LEVEL  = 3'h4,
    RX_HALT_ON_SYNC   = 3'h5,
    RX_HALT_ON_PREAMB = 3'h6,
    RX_UNUSED_HI      = 3'h7
  } rx_exit_t;

  // Exit choices on a receive timeout
  typedef enum logic [1:0] {
    TO_RELAUNCH = 2'h0,
    TO_TRANSMIT = 2'h1,
    TO_LOW_PWR  = 2'h2,
    TO_HALT     = 2'h3
  } timeout_exit_t;

  // Exit choices out of the packet-done state
  typedef enum logic [2:0] {
    PKT_HALT      = 3'h0,
    PKT_TX_ON_FE  = 3'h1,
    PKT_LOW_PWR   = 3'h2,
    PKT_RX_VIA_FS = 3'h3,
    PKT_RX_DIRECT = 3'h4
  } pkt_exit_t;

endpackage : seq_exit_pkg

/* design/seq_next_state.sv */
// Next-state selection of the sequencer
`timescale 1ns/1ps
`default_nettype none

module seq_next_state (
  // Present state and configuration
  input  wire seq_exit_pkg::seq_state_t    state_in,
  input  wire seq_exit_pkg::rx_exit_t      rx_sel_in,
  input  wire seq_exit_pkg::timeout_exit_t to_sel_in,
  input  wire seq_exit_pkg::pkt_exit_t     pkt_sel_in,
  input  wire logic                        lp_sel_in,
  // Commands
  input  wire logic                        launch_in,
  input  wire logic                        stop_in,
  // Events
  input  wire logic                        payload_in,
  input  wire logic                        crc_in,
  input  wire logic                        level_in,
  input  wire logic                        sync_in,
  input  wire logic                        preamble_in,
  input  wire logic                        timeout_in,
  input  wire logic                        fifo_empty_in,
  input  wire logic                        freq_changed_in,
  // Result
  output seq_exit_pkg::seq_state_t         next_state_out
);

  seq_exit_pkg::seq_state_t lp_state;
  seq_exit_pkg::seq_state_t to_state;
  seq_exit_pkg::seq_state_t rx_dest;
  seq_exit_pkg::seq_state_t pkt_dest;
  logic                     rx_hit;

  // Low-power target and timeout destination
  assign lp_state = lp_sel_in ? seq_exit_pkg::IDLE : seq_exit_pkg::HALTED;
  assign to_state = (to_sel_in == seq_exit_pkg::TO_RELAUNCH) ? seq_exit_pkg::RELAUNCH :
                    (to_sel_in == seq_exit_pkg::TO_TRANSMIT) ? seq_exit_pkg::TRANSMIT :
                    (to_sel_in == seq_exit_pkg::TO_LOW_PWR)  ? lp_state :
                                                               seq_exit_pkg::HALTED;

  // Event exit out of Receive
  always_comb begin
    rx_hit  = 1'b0;
    rx_dest = seq_exit_pkg::RECEIVE;
    case (rx_sel_in)
      seq_exit_pkg::RX_PKT_ON_PAYLOAD: begin
        rx_hit  = payload_in;
        rx_dest = seq_exit_pkg::PACKET_DONE;
      end
      seq_exit_pkg::RX_LP_ON_PAYLOAD: begin
        rx_hit  = payload_in;
        rx_dest = lp_state;
      end
      seq_exit_pkg::RX_PKT_ON_CRC: begin
        rx_hit  = crc_in | payload_in;
        rx_dest = crc_in ? seq_exit_pkg::PACKET_DONE : to_state;
      end
      seq_exit_pkg::RX_HALT_ON_LEVEL: begin
        rx_hit  = level_in;
        rx_dest = seq_exit_pkg::HALTED;
      end
      seq_exit_pkg::RX_HALT_ON_SYNC: begin
        rx_hit  = sync_in;
        rx_dest = seq_exit_pkg::HALTED;
      end
      seq_exit_pkg::RX_HALT_ON_PREAMB: begin
        rx_hit  = preamble_in;
        rx_dest = seq_exit_pkg::HALTED;
      end
      default: begin
        rx_hit  = 1'b0;
        rx_dest = seq_exit_pkg::RECEIVE;
      end
    endcase
  end

  // Exit out of the packet-done state
  always_comb begin
    case (pkt_sel_in)
      seq_exit_pkg::PKT_HALT:      pkt_dest = seq_exit_pkg::HALTED;
      seq_exit_pkg::PKT_TX_ON_FE:  pkt_dest = fifo_empty_in ? seq_exit_pkg::TRANSMIT :
                                              seq_exit_pkg::PACKET_DONE;
      seq_exit_pkg::PKT_LOW_PWR:   pkt_dest = lp_state;
      seq_exit_pkg::PKT_RX_VIA_FS: pkt_dest = freq_changed_in ? seq_exit_pkg::FREQ_SYNTH :
                                              seq_exit_pkg::RECEIVE;
      seq_exit_pkg::PKT_RX_DIRECT: pkt_dest = seq_exit_pkg::RECEIVE;
      default:                     pkt_dest = seq_exit_pkg::PACKET_DONE;
    endcase
  end

  // State selection, stop has top priority
  always_comb begin
    next_state_out = state_in;
    if (stop_in) begin
      next_state_out = seq_exit_pkg::HALTED;
    end else begin
      case (state_in)
        seq_exit_pkg::HALTED,
        seq_exit_pkg::IDLE: begin
          if (launch_in) begin
            next_state_out = seq_exit_pkg::RECEIVE;
          end
        end
        seq_exit_pkg::RECEIVE: begin
          if (rx_hit) begin
            next_state_out = rx_dest;
          end else if (timeout_in) begin
            next_state_out = to_state;
          end
        end
        seq_exit_pkg::PACKET_DONE: next_state_out = pkt_dest;
        seq_exit_pkg::FREQ_SYNTH:  next_state_out = seq_exit_pkg::RECEIVE;
        seq_exit_pkg::RELAUNCH:    next_state_out = seq_exit_pkg::RECEIVE;
        seq_exit_pkg::TRANSMIT:    next_state_out = seq_exit_pkg::TRANSMIT;
        default:                   next_state_out = seq_exit_pkg::HALTED;
      endcase
    end
  end

endmodule : seq_next_state

`default_nettype wire

/* test/rx_sequencer_exit_routing_tb.sv */
// Random and corner-case bench for the sequencer exit routing block
`timescale 1ns/1ps
`default_nettype none
`include "seq_exit_consts.svh"

module rx_sequencer_exit_routing_tb;
  logic             clk, nrst, lp, ics, fchg;
  logic             aw_valid, w_valid, b_ready, ar_valid, r_ready;
  logic [11:0]      aw_addr, ar_addr;
  logic [31:0]      w_data, rd;
  logic [8:0]       flg;
  logic [7:0]       cv;
  logic [1:0]       rsp;
  wire logic        aw_ready, w_ready, b_valid, ar_ready, r_valid, idle_sleep;
  wire logic [1:0]  b_resp, r_resp;
  wire logic [31:0] r_data;
  wire logic [2:0]  state;
  int               num_errors = 0;
  int               cmp_count = 0;

  // Free-running 100 MHz clock
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // Flag bits: fifo empty, three wait timeouts, preamble, sync, level, crc, payload
  rx_sequencer_exit_routing i_dut (
    .CLK_IN(clk), .NRST_IN(nrst), .AWADDR_IN(aw_addr), .AWVALID_IN(aw_valid),
    .AWREADY_OUT(aw_ready), .WDATA_IN(w_data), .WSTRB_IN(4'hf), .WVALID_IN(w_valid),
    .WREADY_OUT(w_ready), .BRESP_OUT(b_resp), .BVALID_OUT(b_valid), .BREADY_IN(b_ready),
    .ARADDR_IN(ar_addr), .ARVALID_IN(ar_valid), .ARREADY_OUT(ar_ready), .RDATA_OUT(r_data),
    .RRESP_OUT(r_resp), .RVALID_OUT(r_valid), .RREADY_IN(r_ready),
    .PAYLOAD_COMPLETE_FLAG_IN(flg[0]), .CRC_PASS_FLAG_IN(flg[1]),
    .SIGNAL_LEVEL_FLAG_IN(flg[2]), .SYNC_MATCH_FLAG_IN(flg[3]),
    .PREAMBLE_FOUND_FLAG_IN(flg[4]), .SIGNAL_WAIT_TIMEOUT_IN(flg[5]),
    .PREAMBLE_WAIT_TIMEOUT_IN(flg[6]), .SYNC_WAIT_TIMEOUT_IN(flg[7]),
    .FIFO_EMPTY_FLAG_IN(flg[8]), .FREQ_CHANGED_IN(fchg), .STATE_OUT(state),
    .IDLE_SLEEP_OUT(idle_sleep)
  );

  // Expected state: 0-7 receive codes, 8-12 timeout cases, 16-20 packet-done codes
  function automatic logic [2:0] exp_st(input int s);
    case (s)
      1, 3: return seq_exit_pkg::PACKET_DONE;
      2, 10, 18: return lp ? seq_exit_pkg::IDLE : seq_exit_pkg::HALTED;
      4, 5, 6, 11, 16: return seq_exit_pkg::HALTED;
      8: return seq_exit_pkg::RELAUNCH;
      9, 12, 17: return seq_exit_pkg::TRANSMIT;
      19: return seq_exit_pkg::FREQ_SYNTH;
      default: return seq_exit_pkg::RECEIVE;
    endcase
  endfunction : exp_st

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      num_errors++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic test_done;
    $display("compares %0d mismatches %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : test_done

  // One AXI4-Lite write (w high) or read; each valid dropped once taken
  task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d);
    logic ta, tw, tv;
    @(posedge clk);
    {aw_addr, ar_addr, w_data} <= {a, a, d};
    {aw_valid, w_valid, b_ready, ar_valid, r_ready} <= {w, w, w, !w, !w};
    for (int n = 0; n < 40; n++) begin
      @(negedge clk);
      {ta, tw, tv} = w ? {aw_ready, w_ready, b_valid} : {ar_ready, 1'b0, r_valid};
      rsp = w ? b_resp : r_resp;
      rd = r_data;
      @(posedge clk);
      if (ta) {aw_valid, ar_valid} <= 2'b00;
      if (tw) w_valid <= 1'b0;
      if (tv) begin
        {b_ready, r_ready} <= 2'b00;
        return;
      end
    end
    num_errors++;
    test_done();
  endtask : bus

  // One-cycle event pulse, state read just after it is acted on
  task automatic pulse(input logic [8:0] v);
    @(posedge clk);
    flg <= v;
    @(posedge clk);
    flg <= 9'h000;
    #1;
  endtask : pulse

  task automatic step;
    @(posedge clk);
    #1;
  endtask : step

  // Stop, configure, then launch into Receive with a random low-power choice
  task automatic start(input logic [7:0] cfg);
    {ics, lp} = 2'($urandom_range(0, 3));
    bus(1'b1, `CTRL_ADDR, 32'h0000_0002);
    bus(1'b1, `RX_CFG_ADDR, {24'h0, cfg});
    bus(1'b1, `CTRL_ADDR, {28'h0, ics, lp, 2'b01});
    chk(state, seq_exit_pkg::RECEIVE);
  endtask : start

  initial begin
    {nrst, aw_valid, w_valid, b_ready, ar_valid, r_ready, fchg, lp, ics} = '0;
    {aw_addr, ar_addr, w_data, flg} = '0;
    void'($urandom(32'h82c7_44be));
    repeat (20) @(posedge clk);
    nrst <= 1'b1;
    // Reset value, random read-back, unmapped place
    bus(1'b0, `RX_CFG_ADDR, 32'h0);
    chk(rd, 32'h0000_0000);
    cv = $urandom_range(0, 255);
    bus(1'b1, `RX_CFG_ADDR, {24'h0, cv});
    bus(1'b0, `RX_CFG_ADDR, 32'h0);
    chk(rd, {24'h0, cv});
    bus(1'b1, 12'hff0, 32'h0);
    chk(rsp, `RESP_SLVERR);
    bus(1'b0, 12'hff0, 32'h0);
    chk(rsp, `RESP_SLVERR);
    $display("test registers done");
    // Every receive exit code with its own event; unused codes see all five non-timeout events
    for (int c = 0; c < 8; c++) begin
      start({c[2:0], 2'b11, 3'h0});
      pulse((c == 0 || c == 7) ? 9'h01f : 9'h001 << (c < 3 ? 0 : c - 2));
      chk(state, exp_st(c));
      chk(idle_sleep, (exp_st(c) == seq_exit_pkg::IDLE) && ics);
    end
    $display("test receive exits done");
    // Timeout routes from a random wait timeout; case 4 is payload under code 011
    for (int t = 0; t < 5; t++) begin
      start({(t == 4) ? 3'h3 : 3'h0, (t == 4) ? 2'b01 : t[1:0], 3'h0});
      pulse((t == 4) ? 9'h001 : 9'h020 << $urandom_range(0, 2));
      chk(state, exp_st(8 + t));
      if (t == 0) begin
        step();
        chk(state, seq_exit_pkg::RECEIVE);
      end
      if (t == 1) begin
        bus(1'b1, `CTRL_ADDR, 32'h0000_0001);
        chk(state, seq_exit_pkg::TRANSMIT);
      end
    end
    // Sticky timeout flag reads back beside the state, a written 1 clears it
    bus(1'b0, `STATUS_ADDR, 32'h0);
    chk(rd, 32'h0000_0008 | seq_exit_pkg::TRANSMIT);
    bus(1'b1, `STATUS_ADDR, 32'h0000_0008);
    bus(1'b0, `STATUS_ADDR, 32'h0);
    chk(rd, 32'(seq_exit_pkg::TRANSMIT));
    $display("test timeout exits done");
    // Packet-done exits, held there until the FIFO empties for code 001
    for (int p = 0; p < 5; p++) begin
      start({3'h1, 2'b00, p[2:0]});
      fchg <= (p == 3);
      pulse(9'h001);
      chk(state, seq_exit_pkg::PACKET_DONE);
      if (p == 1) begin
        repeat (3) step();
        chk(state, seq_exit_pkg::PACKET_DONE);
        pulse(9'h100);
      end else step();
      chk(state, exp_st(16 + p));
      if (p == 3) begin
        step();
        chk(state, seq_exit_pkg::RECEIVE);
      end
    end
    $display("test packet-done exits done");
    test_done();
  end
endmodule : rx_sequencer_exit_routing_tb
`default_nettype wire
